// ===== hdl/crm_pkg.sv
// Package for the cable reflectometry monitor: map, fields, types
// Overview of operation
// - Capture extreme sample and threshold crossing
// - Record first-seen times in 8ns steps
// - Timer starts at pulse launch
// - Window limits which samples count
// - Bit 15 takes over both line drivers
// - Bit 11 launches pulse and starts monitor
// - Bit 14 picks slow or fast driver
// - Bits 10:8 set width, zero sends none
// - Zero width still runs full measurement
// - Fast pulses 8ns steps, alternating polarity
// - Bit 13 picks pulse pair, default transmit
// - Bit 12 picks sampled pair, default transmit
// - Bit 7 picks maximum or minimum search
// - Window start high byte, stop low byte
// - Window resets to start 0, stop 255
// - Window counted in 8ns samples, 2048ns
// - Peak at 18h, threshold result at 19h
// - Control 16h, window 17h on page 2
package crm_pkg;
   localparam logic [4:0]  ADDR_PAGE_SELECT = 5'h13;
   localparam logic [4:0]  ADDR_CONTROL     = 5'h16;
   localparam logic [4:0]  ADDR_WINDOW      = 5'h17;
   localparam logic [4:0]  ADDR_PEAK        = 5'h18;
   localparam logic [4:0]  ADDR_THRESH      = 5'h19;
   localparam logic [15:0] DIAG_PAGE        = 16'h0002;
   localparam int          BIT_ENABLE       = 15;
   localparam int          BIT_FAST         = 14;
   localparam int          BIT_TX_PAIR      = 13;
   localparam int          BIT_RX_PAIR      = 12;
   localparam int          BIT_SEND         = 11;
   localparam int          BIT_MIN_MODE     = 7;
   localparam int          WIDTH_LSB        = 8;
   localparam logic [15:0] CONTROL_RESET    = 16'h0000;
   localparam logic [15:0] WINDOW_RESET     = 16'h00ff;
   localparam logic [7:0]  THRESH_RESET     = 8'h00;
   localparam logic [7:0]  NO_TIME          = 8'hff;
   localparam logic [7:0]  MAX_SEED         = 8'h80;
   localparam logic [7:0]  MIN_SEED         = 8'h7f;
   localparam logic [7:0]  LAST_SAMPLE      = 8'hff;
   localparam int          SAMPLE_NS        = 8;

   typedef enum logic [1:0] {
      CRM_IDLE = 2'b00,
      CRM_RUN  = 2'b01
   } crm_state_t;

   typedef struct packed {
      logic [4:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } crm_reg_req_t;

   typedef struct packed {
      logic       owned;
      logic       slow_pulse;
      logic       fast_pulse;
      logic       fast_neg;
      logic       tx_pair_rx;
      logic       rx_pair_rx;
   } crm_drv_t;

   typedef struct packed {
      crm_state_t  state;
      logic [15:0] page;
      logic [15:0] control;
      logic [15:0] window;
      logic [7:0]  thresh;
      logic [7:0]  timer;
      logic [7:0]  peak_val;
      logic [7:0]  peak_time;
      logic        thr_found;
      logic [7:0]  thr_time;
      logic        neg_next;
      crm_drv_t    drv;
      logic [15:0] rdata;
   } crm_regs_t;
endpackage

// ===== hdl/crm_cable_reflectometry_monitor.sv
// Reflectometry control, pulse launch and sample monitor
`timescale 1ns/1ps
module crm_cable_reflectometry_monitor (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire crm_pkg::crm_reg_req_t reg_req,
   output logic [15:0]                reg_rdata,
   input  wire logic                  adc_valid,
   input  wire logic [7:0]            adc_sample,
   output crm_pkg::crm_drv_t          drv,
   output logic                       busy
);

   crm_pkg::crm_regs_t r;
   crm_pkg::crm_regs_t next_r;

   ////////////////////////////////////////////////////////////////////////
   // Signed compare used by peak and threshold search
   function automatic logic beyond(input logic [7:0] a, input logic [7:0] b,
                                   input logic min_mode);
      if (min_mode) begin
         beyond = $signed(a) < $signed(b);
      end else begin
         beyond = $signed(a) > $signed(b);
      end
   endfunction

   logic       on_page;
   logic       min_mode;
   logic       in_win;
   logic       last;

   always_comb begin
      on_page  = (r.page == crm_pkg::DIAG_PAGE);
      min_mode = r.control[crm_pkg::BIT_MIN_MODE];
      in_win   = (r.timer >= r.window[15:8]) &&
                 (r.timer <= r.window[7:0]);
      last     = (r.timer >= r.window[7:0]) ||
                 (r.timer == crm_pkg::LAST_SAMPLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_r = r;
      // Register writes
      if (reg_req.wr) begin
         if (reg_req.addr == crm_pkg::ADDR_PAGE_SELECT) begin
            next_r.page = reg_req.wdata;
         end else if (on_page) begin
            case (reg_req.addr)
               crm_pkg::ADDR_CONTROL: begin
                  next_r.control = reg_req.wdata;
                  if (r.state == crm_pkg::CRM_RUN) begin
                     next_r.control[crm_pkg::BIT_SEND] = 1'b1;
                  end
               end
               crm_pkg::ADDR_WINDOW: next_r.window = reg_req.wdata;
               crm_pkg::ADDR_THRESH: next_r.thresh = reg_req.wdata[7:0];
               default: ;
            endcase
         end
      end
      // Read answer
      if (reg_req.rd) begin
         next_r.rdata = 16'h0000;
         if (reg_req.addr == crm_pkg::ADDR_PAGE_SELECT) begin
            next_r.rdata = r.page;
         end else if (on_page) begin
            case (reg_req.addr)
               crm_pkg::ADDR_CONTROL: next_r.rdata = r.control;
               crm_pkg::ADDR_WINDOW:  next_r.rdata = r.window;
               crm_pkg::ADDR_PEAK:
                  next_r.rdata = {r.peak_time, r.peak_val};
               crm_pkg::ADDR_THRESH:
                  next_r.rdata = {r.thr_found, 7'h00, r.thr_time};
               default: next_r.rdata = 16'h0000;
            endcase
         end
      end
      // Measurement sequence
      case (r.state)
         crm_pkg::CRM_IDLE: begin
            if (next_r.control[crm_pkg::BIT_ENABLE] &&
                next_r.control[crm_pkg::BIT_SEND]) begin
               next_r.state     = crm_pkg::CRM_RUN;
               next_r.timer     = 8'h00;
               next_r.thr_found = 1'b0;
               next_r.thr_time  = crm_pkg::NO_TIME;
               next_r.peak_time = crm_pkg::NO_TIME;
               next_r.peak_val  = next_r.control[crm_pkg::BIT_MIN_MODE] ?
                                  crm_pkg::MIN_SEED : crm_pkg::MAX_SEED;
               if (next_r.control[crm_pkg::BIT_FAST] &&
                   next_r.control[crm_pkg::WIDTH_LSB +: 3] != 3'h0) begin
                  next_r.neg_next = ~r.neg_next;
               end
            end
         end
         crm_pkg::CRM_RUN: begin
            if (adc_valid) begin
               if (in_win) begin
                  if (beyond(adc_sample, r.peak_val, min_mode)) begin
                     next_r.peak_val  = adc_sample;
                     next_r.peak_time = r.timer;
                  end
                  if (!r.thr_found &&
                      beyond(adc_sample, r.thresh, min_mode)) begin
                     next_r.thr_found = 1'b1;
                     next_r.thr_time  = r.timer;
                  end
               end
               next_r.timer = r.timer + 8'h01;
               if (last) begin
                  next_r.state = crm_pkg::CRM_IDLE;
                  next_r.control[crm_pkg::BIT_SEND] = 1'b0;
               end
            end
            if (!r.control[crm_pkg::BIT_ENABLE]) begin
               next_r.state = crm_pkg::CRM_IDLE;
               next_r.control[crm_pkg::BIT_SEND] = 1'b0;
            end
         end
         default: next_r.state = crm_pkg::CRM_IDLE;
      endcase
      // Driver takeover and pulse shaping, one sample clock per width step
      next_r.drv.owned      = next_r.control[crm_pkg::BIT_ENABLE];
      next_r.drv.tx_pair_rx = next_r.control[crm_pkg::BIT_TX_PAIR];
      next_r.drv.rx_pair_rx = next_r.control[crm_pkg::BIT_RX_PAIR];
      next_r.drv.fast_neg   = next_r.neg_next;
      next_r.drv.slow_pulse = 1'b0;
      next_r.drv.fast_pulse = 1'b0;
      if (next_r.state == crm_pkg::CRM_RUN && next_r.drv.owned &&
          next_r.timer <
          {5'h00, next_r.control[crm_pkg::WIDTH_LSB +: 3]}) begin
         if (next_r.control[crm_pkg::BIT_FAST]) begin
            next_r.drv.fast_pulse = 1'b1;
         end else begin
            next_r.drv.slow_pulse = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         r           <= '0;
         r.state     <= crm_pkg::CRM_IDLE;
         r.control   <= crm_pkg::CONTROL_RESET;
         r.window    <= crm_pkg::WINDOW_RESET;
         r.thresh    <= crm_pkg::THRESH_RESET;
         r.peak_time <= crm_pkg::NO_TIME;
         r.peak_val  <= crm_pkg::MAX_SEED;
         r.thr_time  <= crm_pkg::NO_TIME;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign reg_rdata = r.rdata;
   assign drv       = r.drv;
   assign busy      = (r.state == crm_pkg::CRM_RUN);

endmodule // crm_cable_reflectometry_monitor

// ===== verif/crm_cable_line_model.sv
// Cable and converter model: sample strobes and one echo
`timescale 1ns/1ps
module crm_cable_line_model (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire crm_pkg::crm_drv_t drv,
   input  wire logic              busy,
   input  wire logic [7:0]        echo_t,
   input  wire logic [7:0]        echo_v,
   output logic                   adc_valid,
   output logic [7:0]             adc_sample
);
   logic [7:0] idx;
   // Strobe every other clock; index counts from pulse launch
   always @(posedge ref_clk) begin
      adc_valid <= rst_n & !adc_valid;
      if (!busy) idx <= 8'h00;
      else if (adc_valid) idx <= idx + 8'h01;
   end
   // Echo at one time, small alternating noise elsewhere
   assign adc_sample = (drv.owned && idx == echo_t) ? echo_v :
                       (idx[0] ? 8'h01 : 8'hff);
endmodule // crm_cable_line_model

// ===== verif/crm_checker.sv
// Port checker for the reflectometry monitor
`timescale 1ns/1ps
module crm_checker (
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire logic                  ce,
   input wire crm_pkg::crm_reg_req_t reg_req,
   input wire logic [15:0]           reg_rdata,
   input wire logic                  adc_valid,
   input wire logic [7:0]            adc_sample,
   input wire crm_pkg::crm_drv_t     drv,
   input wire logic                  busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic pulse = drv.slow_pulse | drv.fast_pulse;
   sequence launch_s; $rose(busy) ##0 drv.owned; endsequence
   sequence fast_s; $rose(drv.fast_pulse); endsequence
   rd_unmapped_a: assert property (
      ce && reg_req.rd && reg_req.addr == 5'h00 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
   pulse_owned_a: assert property (
      pulse |-> drv.owned && busy) else $error("pulse while not owned");
   one_driver_a: assert property (
      !(drv.slow_pulse && drv.fast_pulse)) else $error("both drivers");
   launch_pulse_a: assert property (
      $rose(pulse) |-> launch_s) else $error("pulse without launch");
   fast_toggle_a: assert property (
      fast_s |-> drv.fast_neg != $past(drv.fast_neg))
      else $error("fast polarity not toggled");
   ce_freeze_a: assert property (
      !ce |=> $stable(drv) && $stable(busy) && $stable(reg_rdata))
      else $error("state moved with ce low");
   run_bound_a: assert property (
      launch_s |-> ##[1:1000] !busy) else $error("run never ended");
endmodule // crm_checker
bind crm_cable_reflectometry_monitor crm_checker crm_checker_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .adc_valid(adc_valid),
   .adc_sample(adc_sample), .drv(drv), .busy(busy));

// ===== verif/cable_reflectometry_monitor_test.sv
// Self-checking bench for the reflectometry monitor
`timescale 1ns/1ps
module cable_reflectometry_monitor_test;
   localparam logic [4:0] a_ctl = crm_pkg::ADDR_CONTROL;
   localparam logic [4:0] a_win = crm_pkg::ADDR_WINDOW;
   localparam logic [4:0] a_pk = crm_pkg::ADDR_PEAK;
   localparam logic [4:0] a_th = crm_pkg::ADDR_THRESH;
   logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rd_seen = 1'b0;
   crm_pkg::crm_reg_req_t reg_req = '0;
   crm_pkg::crm_drv_t drv;
   logic [15:0] reg_rdata, exp_q[$];
   logic adc_valid, busy;
   logic [7:0] adc_sample, et, ev, st, p;
   int fails = 0, checks_done = 0, pw = 0;
   always #10 ref_clk = ~ref_clk;
   crm_cable_reflectometry_monitor crm_cable_reflectometry_monitor_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .adc_valid(adc_valid),
      .adc_sample(adc_sample), .drv(drv), .busy(busy));
   crm_cable_line_model crm_cable_line_model_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .drv(drv), .busy(busy), .echo_t(et), .echo_v(ev),
      .adc_valid(adc_valid), .adc_sample(adc_sample));
   task automatic close_out;
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read results come one cycle after the read edge
   always @(posedge ref_clk) begin
      if (rd_seen) cmp(reg_rdata, exp_q.pop_front());
      rd_seen = reg_req.rd & ce;
      if (!busy) pw = 0;
      else if (ce && adc_valid && (drv.slow_pulse || drv.fast_pulse)) pw++;
   end
   task automatic acc(input logic [4:0] a, input logic w,
                      input logic [15:0] d);
      @(negedge ref_clk);
      reg_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge ref_clk);
      reg_req = '0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      acc(a, 1'b1, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      acc(a, 1'b0, 16'h0000);
   endtask
   task automatic run(input logic [15:0] c, input logic h);
      int n;
      n = 0;
      wr(a_ctl, c);
      cmp({14'h0, drv.owned, busy}, 16'h0003);
      if (h) begin
         ce = 1'b0;
         repeat (2) @(negedge ref_clk);
         ce = 1'b1;
      end
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 2000) begin
         fails++;
         close_out;
      end
      cmp(16'(pw), {13'h0000, c[10:8]});
   endtask
   initial begin
      void'($urandom(32'hfb1b3094));
      et = 8'h0a + 8'($urandom % 200);
      ev = 8'h10 + 8'($urandom % 96);
      st = et + 8'h01;
      p = st[0] ? st : st + 8'h01;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      rd(a_ctl, 16'h0000);
      wr(crm_pkg::ADDR_PAGE_SELECT, crm_pkg::DIAG_PAGE);
      rd(crm_pkg::ADDR_PAGE_SELECT, 16'h0002);
      rd(a_win, 16'h00ff);
      rd(a_pk, 16'hff80);
      rd(a_th, 16'h00ff);
      rd(5'h00, 16'h0000);
      wr(a_th, 16'h0008);
      wr(a_win, 16'h02ff);
      run(16'h8b00, 1'b0);
      rd(a_pk, {et, ev});
      rd(a_th, {8'h80, et});
      rd(a_ctl, 16'h8300);
      wr(a_win, {st, 8'hff});
      run(16'hbb00, 1'b0);
      rd(a_pk, {p, 8'h01});
      rd(a_th, 16'h00ff);
      cmp({14'h0, drv.tx_pair_rx, drv.rx_pair_rx}, 16'h0003);
      wr(a_win, 16'h00ff);
      run(16'h8880, 1'b0);
      rd(a_pk, 16'h00ff);
      rd(a_th, 16'h8000);
      cmp({14'h0, drv.tx_pair_rx, drv.rx_pair_rx}, 16'h0000);
      wr(a_win, 16'h0010);
      for (int k = 0; k < 2; k++) begin
         run(16'hca00, 1'b1);
         cmp({15'h0, drv.fast_neg}, 16'(k == 0));
         rd(a_ctl, 16'hc200);
      end
      wr(a_ctl, 16'h0000);
      cmp({15'h0, drv.owned}, 16'h0000);
      repeat (3) @(negedge ref_clk);
      close_out;
   end
endmodule // cable_reflectometry_monitor_test
